// ==== core/psc_pkg.sv ====
// Shared constants and types of the transceiver status/control register bank.
// Assumes a 20 MHz device clock and a 32-bit AHB-Lite register port.
package psc_pkg;

    // -------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_PHY_EXTENDED_STATUS = 8'h10;
    localparam logic [7:0] IDX_PHY_SPECIFIC_CONTROL = 8'h11;
    localparam logic [7:0] IDX_INTERRUPT_STATUS_ENABLE_ONE = 8'h12;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h19;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h1a;

    // -------------------------------------------------------------------
    // Reset values and masks
    // -------------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0108;
    localparam logic [15:0] CTRL_WMASK = 16'hfb1f;
    localparam logic [15:0] INTERRUPT_STATUS_ENABLE_RESET = 16'h0000;

    // -------------------------------------------------------------------
    // Field positions of the control register
    // -------------------------------------------------------------------
    localparam int CTRL_CLK_DISABLE = 15;
    localparam int CTRL_PS_ENABLE = 14;
    localparam int CTRL_PS_MODE_HI = 13;
    localparam int CTRL_PS_MODE_LO = 12;
    localparam int CTRL_SCR_BYPASS = 11;
    localparam int CTRL_FIFO_HI = 9;
    localparam int CTRL_FIFO_LO = 8;
    localparam int CTRL_COL_FD = 4;
    localparam int CTRL_INT_POL = 3;
    localparam int CTRL_INT_TEST = 2;
    localparam int CTRL_INT_EN = 1;
    localparam int CTRL_INT_OUT = 0;

    // Extended status bit positions
    localparam int STS_LINK = 0;
    localparam int STS_SPEED = 1;
    localparam int STS_DUPLEX = 2;

    // Power-save mode codes
    localparam logic [1:0] PS_MODE_NORMAL = 2'h0;
    localparam logic [1:0] PS_MODE_ACTIVE_SLEEP = 2'h2;

    // Loopback FIFO depth in nibbles for codes 0..3
    localparam logic [3:0] FIFO_NIB_0 = 4'h4;
    localparam logic [3:0] FIFO_NIB_1 = 4'h5;
    localparam logic [3:0] FIFO_NIB_2 = 4'h6;
    localparam logic [3:0] FIFO_NIB_3 = 4'h8;

    // Wrapper interrupt status bits
    localparam int IRQ_BIT_PIN = 0;
    localparam int IRQ_BIT_LINK = 1;
    localparam int IRQ_BIT_WAKE = 2;
    localparam int IRQ_W = 3;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 50;
    localparam longint NLP_PERIOD_MS = 1400;
    localparam longint NLP_PERIOD_CYCLES_DEF = (NLP_PERIOD_MS * 64'd1000000) / CLK_PERIOD_NS;
    localparam int NLP_CNT_W = 25;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSC_PS_AWAKE = 2'b01,
        PSC_PS_SLEEP = 2'b10
    } psc_ps_state_t;

    // Line status reported by the transceiver core
    typedef struct packed {
        logic link_up;
        logic speed_10;
        logic duplex_full;
        logic autoneg_en;
    } psc_line_t;

    // Whole state of the register bank
    typedef struct packed {
        logic dp_write;
        logic rd_wait;
        logic [7:0] dp_idx;
        logic [15:0] rdata;
        logic [15:0] ctrl;
        logic [15:0] interrupt_status_enable;
        logic link;
        logic speed;
        logic duplex;
        logic strap_done;
        logic strap_speed;
        logic strap_duplex;
        psc_ps_state_t ps;
        logic [NLP_CNT_W-1:0] nlp_cnt;
        logic nlp_pulse;
        logic int_q;
        logic link_q;
        logic [IRQ_W-1:0] sts;
        logic [IRQ_W-1:0] ien;
    } psc_state_t;

endpackage

// ==== core/psc_regs.sv ====
// Status and control register bank of a 10/100 transceiver, with AHB-Lite access.
// Assumes a single 20 MHz clock; all inputs are synchronous to it.
`timescale 1ns/1ps

// Summary of operation
// R01: Duplex bit: 1 full; autoneg off gives strap (common mode) or 1 (extended).
// R02: Speed bit resets 1, 1 means 10 Mbps; autoneg off: strap or 1.
// R03: Link bit mirrors common_pinout_mode status link; reading never clears it.
// R04: Clock disable bit acts only while in standard power-down.
// R05: Power-save enable bit lets the selected power-save mode take effect.
// R06: Mode field: 0 normal, 1 reserved, 2 active sleep.
// R07: Active sleep sends link pulse every 1.4 s, wakes on partner.
// R08: Scrambler bypass bit removes scrambler when set.
// R09: Loopback FIFO depth codes give 4, 5, 6, 8 nibbles; reset 5.
// R10: Software picks FIFO depth from packet size and clock accuracy.
// R11: Collision output in full duplex only when enable bit set.
// R12: Interrupt polarity resets 1; 1 idles high, asserts low.
// R13: Test interrupt bit forces interrupt for as long as it is set.
// R14: Interrupt enable gates event interrupts per individual event enables.
// R15: Bit 0 selects pin as power-down input or interrupt output, its active level set by the polarity bit (R12); the power-down input stays active low.
// R16: Control resets to 0x0108; event register at 0x12 resets to zero.
// R17: Event register: upper byte clear-on-read flags, lower byte enables.
// R18: Reserved control bits read zero, writes ignored.
module psc_regs
    import psc_pkg::*;
#(
    parameter int unsigned NLP_PERIOD_CYCLES = int'(NLP_PERIOD_CYCLES_DEF)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire psc_line_t line_status,
    input wire logic enhanced_mode,
    input wire logic strap_speed_10,
    input wire logic strap_full_duplex,
    input wire logic powerdown_state,
    input wire logic partner_detected,
    input wire logic [7:0] event_pulse,
    input wire logic col_raw,
    input wire logic irq_powerdown_pin_i,
    output logic irq_powerdown_pin_o,
    output logic irq_powerdown_pin_oe,
    output logic powerdown_req,
    output logic clk_disable,
    output logic sleep_active,
    output logic nlp_pulse,
    output logic scrambler_bypass,
    output logic [3:0] lpbk_fifo_nibbles,
    output logic col_out,
    output logic irq
);

    // -------------------------------------------------------------------
    // State and helpers
    // -------------------------------------------------------------------
    psc_state_t st;
    psc_state_t next_st;
    logic int_active;
    logic ps_wanted;

    // Register read multiplexer
    function automatic logic [15:0] read_mux(input psc_state_t s, input logic [7:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            IDX_PHY_EXTENDED_STATUS: begin
                v[STS_LINK] = s.link;
                v[STS_SPEED] = s.speed;
                v[STS_DUPLEX] = s.duplex;
            end
            IDX_PHY_SPECIFIC_CONTROL: v = s.ctrl & CTRL_WMASK; // R18
            IDX_INTERRUPT_STATUS_ENABLE_ONE: v = s.interrupt_status_enable;
            IDX_IRQ_STATUS: v[IRQ_W-1:0] = s.sts;
            IDX_IRQ_ENABLE: v[IRQ_W-1:0] = s.ien;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Interrupt condition before polarity
    assign int_active = st.ctrl[CTRL_INT_TEST] // R13
        | (st.ctrl[CTRL_INT_EN] & (|(st.interrupt_status_enable[15:8] & st.interrupt_status_enable[7:0]))); // R14

    // Active sleep requested by software
    assign ps_wanted = st.ctrl[CTRL_PS_ENABLE] // R05
        & (st.ctrl[CTRL_PS_MODE_HI:CTRL_PS_MODE_LO] == PS_MODE_ACTIVE_SLEEP); // R06

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        logic accept;
        logic rd_clr;
        logic [IRQ_W-1:0] sts_clr;
        logic [IRQ_W-1:0] sts_set;
        accept = 1'b0;
        rd_clr = 1'b0;
        sts_clr = '0;
        sts_set = '0;
        next_st = st;
        next_st.nlp_pulse = 1'b0;

        // Data phase of a write commits the word
        if (st.dp_write) begin
            unique case (st.dp_idx)
                IDX_PHY_SPECIFIC_CONTROL: next_st.ctrl = hwdata[15:0] & CTRL_WMASK; // R18
                IDX_INTERRUPT_STATUS_ENABLE_ONE: next_st.interrupt_status_enable[7:0] = hwdata[7:0]; // R17
                IDX_IRQ_CLEAR: sts_clr = hwdata[IRQ_W-1:0];
                IDX_IRQ_ENABLE: next_st.ien = hwdata[IRQ_W-1:0];
                default: next_st.ctrl = next_st.ctrl;
            endcase
        end

        // Read wait state: load data, apply clear-on-read
        if (st.rd_wait) begin
            next_st.rdata = read_mux(st, st.dp_idx);
            next_st.rd_wait = 1'b0;
            rd_clr = (st.dp_idx == IDX_INTERRUPT_STATUS_ENABLE_ONE); // R17
        end

        // Address phase
        accept = hsel & htrans[1] & hready;
        next_st.dp_write = accept & hwrite;
        if (accept) begin
            next_st.dp_idx = haddr[9:2];
            next_st.rd_wait = ~hwrite;
        end

        // Event flags: a new event wins over the read clear
        next_st.interrupt_status_enable[15:8] = (st.interrupt_status_enable[15:8] & ~{8{rd_clr}}) | event_pulse; // R17

        // Strap capture once after reset release
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.strap_speed = strap_speed_10;
            next_st.strap_duplex = strap_full_duplex;
        end

        // Extended status bits
        next_st.link = line_status.link_up; // R03
        if (line_status.autoneg_en) begin
            next_st.speed = line_status.speed_10; // R02
            next_st.duplex = line_status.duplex_full; // R01
        end else if (enhanced_mode) begin
            next_st.speed = 1'b1; // R02
            next_st.duplex = 1'b1; // R01
        end else begin
            next_st.speed = st.strap_speed; // R02
            next_st.duplex = st.strap_duplex; // R01
        end

        // Active sleep sequencer
        unique case (st.ps)
            PSC_PS_AWAKE: begin
                if (ps_wanted && !partner_detected) begin
                    next_st.ps = PSC_PS_SLEEP; // R06
                    next_st.nlp_cnt = '0;
                end
            end
            PSC_PS_SLEEP: begin
                if (partner_detected) begin
                    next_st.ps = PSC_PS_AWAKE; // R07
                    next_st.ctrl[CTRL_PS_ENABLE] = 1'b0;
                    sts_set[IRQ_BIT_WAKE] = 1'b1;
                end else if (!ps_wanted) begin
                    next_st.ps = PSC_PS_AWAKE; // R05
                end else if (st.nlp_cnt == NLP_CNT_W'(NLP_PERIOD_CYCLES - 1)) begin
                    next_st.nlp_cnt = '0; // R07
                    next_st.nlp_pulse = 1'b1;
                end else begin
                    next_st.nlp_cnt = st.nlp_cnt + 1'b1;
                end
            end
        endcase

        // Wrapper sticky events: set wins over clear
        next_st.int_q = int_active;
        next_st.link_q = st.link;
        sts_set[IRQ_BIT_PIN] = int_active & ~st.int_q;
        sts_set[IRQ_BIT_LINK] = st.link ^ st.link_q;
        next_st.sts = (st.sts & ~sts_clr) | sts_set;
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st.dp_write <= 1'b0;
            st.rd_wait <= 1'b0;
            st.dp_idx <= 8'h00;
            st.rdata <= 16'h0000;
            st.ctrl <= CTRL_RESET; // R16
            st.interrupt_status_enable <= INTERRUPT_STATUS_ENABLE_RESET; // R16
            st.link <= 1'b0;
            st.speed <= 1'b1; // R02
            st.duplex <= 1'b0;
            st.strap_done <= 1'b0;
            st.strap_speed <= 1'b1;
            st.strap_duplex <= 1'b0;
            st.ps <= PSC_PS_AWAKE;
            st.nlp_cnt <= '0;
            st.nlp_pulse <= 1'b0;
            st.int_q <= 1'b0;
            st.link_q <= 1'b0;
            st.sts <= '0;
            st.ien <= '0;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Bus answers: one wait state on reads only
    assign hreadyout = ~st.rd_wait;
    assign hresp = 1'b0;
    assign hrdata = {16'h0000, st.rdata};

    // Pin: level follows polarity; driven only when selected as output
    assign irq_powerdown_pin_o = int_active ^ st.ctrl[CTRL_INT_POL]; // R12
    assign irq_powerdown_pin_oe = st.ctrl[CTRL_INT_OUT]; // R15
    assign powerdown_req = ~st.ctrl[CTRL_INT_OUT] & ~irq_powerdown_pin_i; // R15

    // Transceiver controls
    assign clk_disable = st.ctrl[CTRL_CLK_DISABLE] & powerdown_state; // R04
    assign sleep_active = (st.ps == PSC_PS_SLEEP);
    assign nlp_pulse = st.nlp_pulse;
    assign scrambler_bypass = st.ctrl[CTRL_SCR_BYPASS]; // R08
    assign col_out = col_raw & (~st.duplex | st.ctrl[CTRL_COL_FD]); // R11

    // FIFO depth decode
    always_comb begin
        unique case (st.ctrl[CTRL_FIFO_HI:CTRL_FIFO_LO])
            2'h0: lpbk_fifo_nibbles = FIFO_NIB_0; // R09
            2'h1: lpbk_fifo_nibbles = FIFO_NIB_1;
            2'h2: lpbk_fifo_nibbles = FIFO_NIB_2;
            2'h3: lpbk_fifo_nibbles = FIFO_NIB_3;
        endcase
    end

    // Wrapper interrupt level
    assign irq = |(st.sts & st.ien);

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_duplex_forced: assert property ( // R01
        (!line_status.autoneg_en && enhanced_mode) |=> st.duplex)
        else $error("Duplex not forced full with autoneg off");

    a_speed_forced: assert property ( // R02
        (!line_status.autoneg_en && enhanced_mode) |=> st.speed)
        else $error("Speed not forced to 10 with autoneg off");

    a_link_mirror: assert property ( // R03
        ##1 (st.link == $past(line_status.link_up)))
        else $error("Link status does not mirror the input");

    a_clk_gate: assert property ( // R04
        clk_disable |-> (powerdown_state && st.ctrl[CTRL_CLK_DISABLE]))
        else $error("Clock disabled outside power-down");

    a_sleep_enable: assert property ( // R05
        sleep_active |-> $past(st.ctrl[CTRL_PS_ENABLE]))
        else $error("Sleeping without power-save enable");

    a_sleep_mode: assert property ( // R06
        ($rose(sleep_active)) |-> ($past(st.ctrl[13:12]) == 2'h2))
        else $error("Sleep entered with wrong mode code");

    a_wake_partner: assert property ( // R07
        (sleep_active && partner_detected) |=> (!sleep_active && !st.ctrl[CTRL_PS_ENABLE]))
        else $error("No wake on partner detection");

    a_fifo_depth: assert property ( // R09
        (st.ctrl[9:8] == 2'h3) |-> (lpbk_fifo_nibbles == 4'h8))
        else $error("FIFO depth code 3 is not 8 nibbles");

    a_col_gate: assert property ( // R11
        col_out |-> (col_raw && (!st.duplex || st.ctrl[CTRL_COL_FD])))
        else $error("Collision shown in full duplex while disabled");

    a_test_force: assert property ( // R13
        st.ctrl[CTRL_INT_TEST] [*2] |-> (irq_powerdown_pin_o != st.ctrl[CTRL_INT_POL]))
        else $error("Test interrupt not held at active level");

    a_event_gate: assert property ( // R14
        (!st.ctrl[CTRL_INT_EN] && !st.ctrl[CTRL_INT_TEST])
            |-> (irq_powerdown_pin_o == st.ctrl[CTRL_INT_POL]))
        else $error("Event interrupt with enable bit clear");

    a_pin_input: assert property ( // R15
        !st.ctrl[CTRL_INT_OUT] |-> !irq_powerdown_pin_oe)
        else $error("Pin driven while set as power-down input");

    a_flag_sets: assert property ( // R17
        event_pulse[0] |=> st.interrupt_status_enable[8])
        else $error("Event flag not set after event");

    a_reserved_zero: assert property ( // R18
        (st.ctrl[10] == 1'b0) && (st.ctrl[7:5] == 3'h0))
        else $error("Reserved control bits not zero");

endmodule

// ==== verification/psc_regs_tb_top.sv ====
// Self-checking bench of the transceiver status/control register bank.
// Assumes psc_pkg and psc_regs are compiled first; the bench drives every port.
`timescale 1ns/1ps
module psc_regs_tb_top;
    import psc_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    localparam int unsigned NLP_CYC = 20;
    // Power-save words that must not start active sleep
    logic [31:0] ps_words [3] = '{32'h2000, 32'h4000, 32'h5000};
    logic ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, d, es;
    logic [1:0] htrans;
    logic [2:0] hsize;
    psc_line_t ls, ls_n;
    logic enh_n;
    logic enh, strap_spd, strap_dup, pd_state, partner, col_raw, pin_i, pin_o, pin_oe, pd_drive;
    logic pd_req, clk_dis, sleep, nlp, scr_byp, col_out, irq;
    logic [7:0] ev;
    logic [3:0] nib;
    int num_errors, check_count, n;

    assign hready = hreadyout;
    // Pin level: the block drives it while enabled, otherwise the bench does
    assign pin_i = pin_oe ? pin_o : pd_drive;

    psc_regs #(.NLP_PERIOD_CYCLES(NLP_CYC)) dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .line_status(ls), .enhanced_mode(enh), .strap_speed_10(strap_spd),
        .strap_full_duplex(strap_dup), .powerdown_state(pd_state), .partner_detected(partner),
        .event_pulse(ev), .col_raw(col_raw), .irq_powerdown_pin_i(pin_i),
        .irq_powerdown_pin_o(pin_o), .irq_powerdown_pin_oe(pin_oe), .powerdown_req(pd_req),
        .clk_disable(clk_dis), .sleep_active(sleep), .nlp_pulse(nlp),
        .scrambler_bypass(scr_byp), .lpbk_fifo_nibbles(nib), .col_out(col_out), .irq(irq));

    // ---------------------------------------------------------------
    // Expectations and bus tasks
    // ---------------------------------------------------------------
    // Extended status word from line state, mode and straps
    function automatic logic [31:0] exp_sts(input psc_line_t l, input logic e);
        if (l.autoneg_en) begin
            return {29'h0, l.duplex_full, l.speed_10, l.link_up};
        end
        if (e) begin
            return {29'h0, 2'h3, l.link_up};
        end
        return {29'h0, strap_dup, strap_spd, l.link_up};
    endfunction

    function automatic logic [3:0] exp_nib(input logic [1:0] c);
        case (c)
            2'h0: return 4'h4;
            2'h1: return 4'h5;
            2'h2: return 4'h6;
            default: return 4'h8;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One single AHB-Lite transfer; waits on hready in each phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
        chk("hresp", 0, hresp);
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] r;
        xfer(1'b1, a, wd, r);
    endtask

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    task automatic pulse_ev(input logic [7:0] v);
        @(posedge ref_clk);
        ev <= v;
        @(posedge ref_clk);
        ev <= 8'h00;
        cyc(3);
    endtask

    task automatic stop_test;
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, ev, pd_state, partner, col_raw} = '0;
        hsize = 3'h2;
        ls = '{link_up: 1'b0, speed_10: 1'b1, duplex_full: 1'b0, autoneg_en: 1'b1};
        {enh, strap_spd, strap_dup, pd_drive} = 4'b0011;
        rst = 1'b1;
        num_errors = 0;
        check_count = 0;
        void'($urandom(66883));
        cyc(2);
        chk("pin_o", 1, pin_o);
        chk("pin_oe", 0, pin_oe);
        chk("fifo", 4'h5, nib);
        @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk("control", 32'h44, 32'h0108);
        rd_chk("events", 32'h48, 32'h0);
        rd_chk("status", 32'h40, 32'h2);
        wr(32'h7c, 32'hffff);
        rd_chk("unmapped", 32'h7c, 32'h0);
        // Random control words and line states, first two forced to autoneg off
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            ls_n = psc_line_t'(4'($urandom));
            enh_n = 1'($urandom);
            if (i < 2) begin
                ls_n.autoneg_en = 1'b0;
                enh_n = i[0];
            end
            ls <= ls_n;
            enh <= enh_n;
            es = exp_sts(ls_n, enh_n);
            pd_state <= 1'($urandom);
            pd_drive <= 1'($urandom);
            col_raw <= 1'($urandom);
            d = $urandom;
            wr(32'h44, d);
            rd_chk("control", 32'h44, d & 32'hfb1f);
            rd_chk("status", 32'h40, es);
            rd_chk("status", 32'h40, es);
            cyc(1);
            chk("clk_dis", d[15] & pd_state, clk_dis);
            chk("scr_byp", d[11], scr_byp);
            chk("fifo", exp_nib(d[9:8]), nib);
            chk("col", {col_raw & (~es[2] | d[4])}, col_out);
            chk("pin_oe", d[0], pin_oe);
            chk("pd_req", {~d[0] & ~pd_drive}, pd_req);
        end
        // Event interrupts, polarity and test interrupt
        wr(32'h44, 32'h0003);
        wr(32'h48, 32'h00ff);
        rd_chk("events", 32'h48, 32'h00ff);
        chk("pin_o", 0, pin_o);
        pulse_ev(8'h25);
        chk("pin_o", 1, pin_o);
        rd_chk("events", 32'h48, 32'h25ff);
        rd_chk("events", 32'h48, 32'h00ff);
        chk("pin_o", 0, pin_o);
        wr(32'h44, 32'h0009);
        pulse_ev(8'h80);
        chk("pin_o", 1, pin_o);
        rd_chk("events", 32'h48, 32'h80ff);
        wr(32'h44, 32'h000d);
        cyc(5);
        chk("pin_o", 0, pin_o);
        wr(32'h44, 32'h0009);
        cyc(2);
        chk("pin_o", 1, pin_o);
        // Power-save modes that must not sleep, then active sleep and wake
        foreach (ps_words[k]) begin
            wr(32'h44, ps_words[k]);
            cyc(3);
            chk("sleep", 0, sleep);
        end
        wr(32'h68, 32'h0);
        wr(32'h64, 32'h7);
        rd_chk("irq_sts", 32'h60, 32'h0);
        wr(32'h44, 32'h6000);
        cyc(3);
        chk("sleep", 1, sleep);
        n = 0;
        repeat (2 * NLP_CYC) begin
            @(negedge ref_clk);
            n += int'(nlp === 1'b1);
        end
        chk("nlp_count", 2, n);
        @(posedge ref_clk);
        partner <= 1'b1;
        cyc(3);
        chk("sleep", 0, sleep);
        rd_chk("irq_sts", 32'h60, 32'h4);
        chk("irq", 0, irq);
        wr(32'h68, 32'h4);
        cyc(2);
        chk("irq", 1, irq);
        wr(32'h64, 32'h4);
        cyc(2);
        chk("irq", 0, irq);
        stop_test();
    end
endmodule
